// File: mac_reset_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "mac_reset_regs.vh"

module mac_reset_ctrl #(
    parameter ADDR_W = 7,
    // crystal is called ready on the edge after it has shown this many edges
    parameter XTAL_EDGES = 8'h10
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    input wire ce,
    // register access from the spi slave (same clock)
    input wire reg_wr,
    input wire reg_rd,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    // spi slave state
    input wire spi_slave_in_reset,
    input wire cs_n_pin,
    // clock status and power control (async)
    input wire oscillator_clock_ready,
    input wire crystal_clock_pin,
    input wire software_power_down_bit,
    // mac core reset outputs
    output reg mac_core_reset,
    output reg mac_logic_reset,
    output reg core_on_oscillator,
    // error injection hooks on the output path
    input wire oa_data_xfer,
    input wire oa_ctrl_burst_wr,
    input wire oa_ctrl_rd,
    input wire generic_prot_rd,
    input wire echo_word_first,
    input wire footer_parity_in,
    input wire footer_ts_parity_in,
    input wire [31:0] echo_word_in,
    input wire [31:0] compl_word_in,
    input wire [7:0] check_byte_in,
    output reg footer_parity_out,
    output reg footer_ts_parity_out,
    output reg [31:0] echo_word_out,
    output reg [31:0] compl_word_out,
    output reg [7:0] check_byte_out
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire cs_n_s;
    wire cs_rise;
    wire cs_fall;
    wire xtal_rise;
    wire osc_s;
    wire pd_s;

    // select idles high and the oscillator reads ready out of reset: no false edge, no zero status bit
    sync_edge #(.INIT(1'b1)) u_cs (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .d_async(cs_n_pin),
        .q(cs_n_s), .rise(cs_rise), .fall(cs_fall)
    );
    sync_edge u_xtal (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .d_async(crystal_clock_pin),
        .q(), .rise(xtal_rise), .fall()
    );
    sync_edge #(.INIT(1'b1)) u_osc (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .d_async(oscillator_clock_ready),
        .q(osc_s), .rise(), .fall()
    );
    sync_edge u_pd (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .d_async(software_power_down_bit),
        .q(pd_s), .rise(), .fall()
    );

    // ------------------------------------------------------------
    // crystal detection: a run of edges without a long gap
    // ------------------------------------------------------------
    reg [7:0] xtal_cnt_r;
    reg [3:0] xtal_gap_r;
    reg xtal_ready_r;

    // a stopped crystal drops the count, so ready follows the clock
    always @(posedge clk_sys) begin
        if (rst) begin
            xtal_cnt_r <= 8'h00;
            xtal_gap_r <= 4'h0;
            xtal_ready_r <= 1'b0;
        end else if (ce) begin
            if (xtal_rise) begin
                xtal_gap_r <= 4'h0;
                if (xtal_cnt_r != XTAL_EDGES)
                    xtal_cnt_r <= xtal_cnt_r + 8'h01;
                else
                    xtal_ready_r <= 1'b1;
            end else if (xtal_gap_r == 4'hf) begin
                xtal_cnt_r <= 8'h00;
                xtal_ready_r <= 1'b0;
            end else begin
                xtal_gap_r <= xtal_gap_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // key sequence state machine
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_RST1 = 3'b010;
    localparam ST_REL1 = 3'b100;

    reg [2:0] key_st_r;
    reg [2:0] key_st_nxt;
    reg logic_rst_pend_r;
    reg release_req_r;
    reg [7:0] cs_low_cnt_r;
    reg inject_r;
    localparam [31:0] INJ_RST = `RST_SPI_OUTPUT_ERROR_INJECT;

    wire key_wr = reg_wr && (reg_addr == `ADDR_SOFTWARE_RESET_KEY);
    wire [15:0] key = reg_wdata[15:0];
    wire pair_rst = key_wr && (key_st_r == ST_RST1) && (key == `KEY_MAC_RESET_2);
    wire pair_rel = key_wr && (key_st_r == ST_REL1) && (key == `KEY_RELEASE_2);
    wire cs_long = (cs_low_cnt_r >= `CS_MIN_HOLD_CYC);

    // any other key write breaks a pair in progress
    always @* begin
        key_st_nxt = key_st_r;
        if (key_wr) begin
            case (key)
                `KEY_MAC_RESET_1: key_st_nxt = ST_RST1;
                `KEY_RELEASE_1: key_st_nxt = ST_REL1;
                default: key_st_nxt = ST_IDLE;
            endcase
        end
    end

    // chip-select low time, counted for the minimum hold check
    always @(posedge clk_sys) begin
        if (rst) begin
            cs_low_cnt_r <= 8'h00;
        end else if (ce) begin
            if (cs_fall)
                cs_low_cnt_r <= 8'h01; // the falling cycle is already a low cycle
            else if (!cs_n_s && cs_low_cnt_r != 8'hff)
                cs_low_cnt_r <= cs_low_cnt_r + 8'h01;
        end
    end

    // key state, pending reset and core release
    always @(posedge clk_sys) begin
        if (rst) begin
            key_st_r <= ST_IDLE;
            logic_rst_pend_r <= 1'b0;
            release_req_r <= 1'b0;
            mac_logic_reset <= 1'b0;
            mac_core_reset <= 1'b1;
            core_on_oscillator <= 1'b0;
        end else if (ce) begin
            case (key_st_r)
                ST_IDLE, ST_RST1, ST_REL1: key_st_r <= key_st_nxt;
                default: key_st_r <= ST_IDLE;
            endcase
            // fires on chip select rising, only after a long enough frame
            mac_logic_reset <= 1'b0;
            if (logic_rst_pend_r && cs_rise) begin
                logic_rst_pend_r <= 1'b0;
                mac_logic_reset <= cs_long && !pd_s;
            end
            // a pair landing with a rise wins and waits for the next rise
            if (pair_rst && !pd_s)
                logic_rst_pend_r <= 1'b1;
            if (pair_rel)
                release_req_r <= 1'b1;
            // crystal wins whenever present; oscillator release is the fallback
            if (xtal_ready_r) begin
                mac_core_reset <= 1'b0;
                core_on_oscillator <= 1'b0;
            end else if (release_req_r && osc_s) begin
                mac_core_reset <= 1'b0;
                core_on_oscillator <= 1'b1;
            end else begin
                mac_core_reset <= 1'b1;
                core_on_oscillator <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // error-inject register and read data
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            inject_r <= INJ_RST[`BIT_INJECT_ERROR_ENABLE];
            reg_rdata <= 32'h00000000;
        end else if (ce) begin
            if (reg_wr && reg_addr == `ADDR_SPI_OUTPUT_ERROR_INJECT)
                inject_r <= reg_wdata[`BIT_INJECT_ERROR_ENABLE];
            if (reg_rd) begin
                // the host must not burst into the status word
                if (spi_slave_in_reset)
                    reg_rdata <= 32'h00000000;
                else if (reg_addr == `ADDR_MAC_RESET_CLOCK_STATUS)
                    reg_rdata <= {30'h0, !mac_core_reset && !core_on_oscillator, osc_s};
                else if (reg_addr == `ADDR_SPI_OUTPUT_ERROR_INJECT)
                    reg_rdata <= {31'h0, inject_r};
                else
                    reg_rdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // output path corruption, registered toward the shifter
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            footer_parity_out <= 1'b0;
            footer_ts_parity_out <= 1'b0;
            echo_word_out <= 32'h00000000;
            compl_word_out <= 32'h00000000;
            check_byte_out <= 8'h00;
        end else if (ce) begin
            footer_parity_out <= footer_parity_in ^ (inject_r & oa_data_xfer);
            footer_ts_parity_out <= footer_ts_parity_in ^ (inject_r & oa_data_xfer);
            echo_word_out <= echo_word_in ^ {inject_r & oa_ctrl_burst_wr & !echo_word_first, 31'h0};
            compl_word_out <= compl_word_in ^ {inject_r & oa_ctrl_rd, 31'h0};
            check_byte_out <= check_byte_in ^ {8{inject_r & generic_prot_rd}};
        end
    end
endmodule // mac_reset_ctrl

`default_nettype wire

// File: mac_reset_regs.vh
`ifndef MAC_RESET_REGS_VH
`define MAC_RESET_REGS_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_MAC_RESET_CLOCK_STATUS 7'h3b
`define ADDR_SOFTWARE_RESET_KEY 7'h3c
`define ADDR_SPI_OUTPUT_ERROR_INJECT 7'h3d

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define BIT_OSCILLATOR_CLOCK_READY 0
`define BIT_CRYSTAL_CLOCK_READY 1
`define BIT_INJECT_ERROR_ENABLE 0
`define RST_MAC_RESET_CLOCK_STATUS 32'h00000003
`define RST_SPI_OUTPUT_ERROR_INJECT 32'h00000000

// ------------------------------------------------------------
// reset keys
// ------------------------------------------------------------
`define KEY_MAC_RESET_1 16'h4f1c
`define KEY_MAC_RESET_2 16'hc1f4
`define KEY_RELEASE_1 16'h6f1a
`define KEY_RELEASE_2 16'ha1f6

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CS_MIN_HOLD_NS 100
`define CLK_SYS_PERIOD_NS 40
// least time rounds up
`define CS_MIN_HOLD_CYC ((`CS_MIN_HOLD_NS + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)

`endif

// File: sync_edge.v
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser with edge detection on the second stage
module sync_edge #(
    // level the stages take in reset; match the pin's idle level to avoid a false edge
    parameter INIT = 1'b0
) (
    // clock
    input wire clk_sys,
    input wire rst,
    input wire ce,
    // async level
    input wire d_async,
    // synchronised level and edges
    output wire q,
    output wire rise,
    output wire fall
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // s1 feeds only s2; edges come from s2 against s3
    always @(posedge clk_sys) begin
        if (rst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else if (ce) begin
            s1_r <= d_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign q = s2_r;
    assign rise = ce & s2_r & ~s3_r;
    assign fall = ce & ~s2_r & s3_r;
endmodule // sync_edge

`default_nettype wire

// File: mac_reset_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_reset_regs.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module mac_reset_ctrl_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // register side
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic spi_slave_in_reset,
    input wire logic cs_n_pin,
    input wire logic software_power_down_bit,
    // reset outputs
    input wire logic mac_core_reset,
    input wire logic mac_logic_reset,
    // injection path
    input wire logic oa_data_xfer,
    input wire logic oa_ctrl_burst_wr,
    input wire logic echo_word_first,
    input wire logic generic_prot_rd,
    input wire logic footer_parity_in,
    input wire logic footer_parity_out,
    input wire logic [31:0] echo_word_in,
    input wire logic [31:0] echo_word_out,
    input wire logic [7:0] check_byte_in,
    input wire logic [7:0] check_byte_out
);
    logic live_r;
    logic inj_r;
    logic [2:0] flip_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // shadow of the inject bit; flips lag one cycle like the outputs
    always @(posedge clk_sys) begin
        live_r <= !rst;
        // frozen with the design while the clock enable is low
        if (rst)
            inj_r <= 1'b0;
        else if (ce && reg_wr && reg_addr == `ADDR_SPI_OUTPUT_ERROR_INJECT)
            inj_r <= reg_wdata[0];
        if (ce)
            flip_r <= {inj_r & oa_data_xfer, inj_r & oa_ctrl_burst_wr & !echo_word_first, inj_r & generic_prot_rd};
    end
    sequence lone_pulse;
        mac_logic_reset ##1 !mac_logic_reset;
    endsequence
    rst_state_a: assert property ($past(rst) |-> mac_core_reset && !mac_logic_reset && reg_rdata == 32'h0)
        else $error("reset state wrong");
    slave_read_a: assert property (reg_rd && spi_slave_in_reset |=> reg_rdata == 32'h0)
        else $error("read during slave reset not zero");
    status_rsvd_a: assert property (reg_rd && reg_addr == `ADDR_MAC_RESET_CLOCK_STATUS |=> reg_rdata[31:2] == 30'h0)
        else $error("status upper bits set");
    pulse_once_a: assert property (mac_logic_reset |-> lone_pulse)
        else $error("logic reset longer than one cycle");
    pulse_cs_a: assert property (mac_logic_reset |-> $past(cs_n_pin, 3))
        else $error("logic reset before select high");
    pd_block_a: assert property (mac_logic_reset |-> !$past(software_power_down_bit, 3))
        else $error("logic reset during power down");
    parity_flip_a: assert property (live_r |-> footer_parity_out == ($past(footer_parity_in) ^ flip_r[2]))
        else $error("footer parity wrong");
    echo_flip_a: assert property (live_r |-> echo_word_out == ($past(echo_word_in) ^ {flip_r[1], 31'h0}))
        else $error("echo word wrong");
    crc_flip_a: assert property (live_r |-> check_byte_out == ($past(check_byte_in) ^ {8{flip_r[0]}}))
        else $error("check byte wrong");
endmodule // mac_reset_ctrl_assertions
bind mac_reset_ctrl mac_reset_ctrl_assertions i_mac_reset_ctrl_assertions (.*);
`default_nettype wire

// File: spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host acting as spi master
// ----------------------------------------
module spi_host_model (
    // clock
    input wire logic clk_sys,
    // requests toward the slave
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [6:0] reg_addr,
    output var logic [31:0] reg_wdata,
    output var logic cs_n_pin,
    // read answer
    input wire logic [31:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata, cs_n_pin} = {2'h0, 7'h0, 32'h0, 1'h1};
    // one access; stale bus inverted so nothing leans on old values
    // one access per two clocks keeps the host inside the debug access rate
    task automatic strobe(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge clk_sys);
        #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    endtask
    // single register read only, never a burst
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        strobe(1'b0, a, 32'h0);
        d = reg_rdata;
    endtask
    // three key writes in one frame, select held well past 100 ns
    task automatic keys(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        cs_n_pin = 1'b0;
        strobe(1'b1, 7'h3c, {16'h0, a});
        strobe(1'b1, 7'h3c, {16'h0, b});
        strobe(1'b1, 7'h3c, {16'h0, c});
        repeat (3) @(posedge clk_sys);
        #1 cs_n_pin = 1'b1;
    endtask
    // bare select frame of n clocks, to probe the minimum hold
    task automatic frame(input int n);
        cs_n_pin = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1 cs_n_pin = 1'b1;
    endtask
endmodule // spi_host_model
`default_nettype wire

// File: mac_reset_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_reset_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t got %h", $time, (a)); end end
module mac_reset_ctrl_test;
    logic clk_sys = 1'b0;
    logic crystal_clock_pin = 1'b0;
    logic rst, reg_wr, reg_rd, cs_n_pin, spi_slave_in_reset, software_power_down_bit, ce, oscillator_clock_ready;
    logic [6:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, echo_word_out, compl_word_out, pat;
    logic [7:0] check_byte_out;
    logic mac_core_reset, mac_logic_reset, core_on_oscillator, footer_parity_out, footer_ts_parity_out, xtal_on;
    logic oa_data_xfer, oa_ctrl_burst_wr, echo_word_first, oa_ctrl_rd, generic_prot_rd;
    wire footer_parity_in = pat[0];
    wire footer_ts_parity_in = pat[1];
    wire [31:0] echo_word_in = pat;
    wire [31:0] compl_word_in = ~pat;
    wire [7:0] check_byte_in = pat[7:0];
    int mismatches = 0, total_checks = 0, pulses = 0;
    // rows: {inject, data, burst, first, read, generic} beside flips {par, ts, echo, compl, crc}
    logic [10:0] rows [7] = '{11'b010000_00000, 11'b110000_11000, 11'b101000_00100, 11'b101100_00000,
                              11'b100010_00010, 11'b100001_00001, 11'b011011_00000};
    mac_reset_ctrl i_mac_reset_ctrl (.*);
    spi_host_model i_spi_host_model (.*);
    // system clock and a free crystal only while enabled
    always #20 clk_sys = ~clk_sys;
    always #160 crystal_clock_pin = xtal_on & ~crystal_clock_pin;
    always @(posedge clk_sys) if (mac_logic_reset === 1'b1) pulses <= pulses + 1;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait for the core reset level
    task automatic wait_core(input logic v);
        for (int n = 0; mac_core_reset !== v; n++) begin
            if (n > 400) begin
                mismatches++;
                end_of_test();
            end
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic key_run(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input int exp);
        int p0;
        p0 = pulses;
        i_spi_host_model.keys(a, b, c);
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK(pulses - p0, exp)
    endtask
    // pair written first, then a bare select frame of n clocks
    task automatic short_run(input int n, input int exp);
        int p0;
        p0 = pulses;
        i_spi_host_model.strobe(1'b1, `ADDR_SOFTWARE_RESET_KEY, {16'h0, `KEY_MAC_RESET_1});
        i_spi_host_model.strobe(1'b1, `ADDR_SOFTWARE_RESET_KEY, {16'h0, `KEY_MAC_RESET_2});
        i_spi_host_model.frame(n);
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK(pulses - p0, exp)
    endtask
    initial begin
        logic [5:0] m;
        logic [4:0] f;
        logic [31:0] d;
        {rst, xtal_on, software_power_down_bit, spi_slave_in_reset, ce, oscillator_clock_ready} = 6'b100011;
        {oa_data_xfer, oa_ctrl_burst_wr, echo_word_first, oa_ctrl_rd, generic_prot_rd, pat} = {5'h0, 32'h0};
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        `CHK(mac_core_reset, 1'b1)
        i_spi_host_model.rd(`ADDR_MAC_RESET_CLOCK_STATUS, d);
        `CHK(d, 32'h1)
        i_spi_host_model.rd(7'h10, d);
        `CHK(d, 32'h0)
        for (int i = 0; i < 7; i++) begin
            {m, f} = rows[i];
            i_spi_host_model.strobe(1'b1, `ADDR_SPI_OUTPUT_ERROR_INJECT, {31'h0, m[5]});
            {oa_data_xfer, oa_ctrl_burst_wr, echo_word_first, oa_ctrl_rd, generic_prot_rd} = m[4:0];
            pat = 32'h800000a4 + 32'(i);
            @(posedge clk_sys);
            #1;
            `CHK(footer_parity_out, pat[0] ^ f[4])
            `CHK(footer_ts_parity_out, pat[1] ^ f[3])
            `CHK(echo_word_out, pat ^ {f[2], 31'h0})
            `CHK(compl_word_out, ~pat ^ {f[1], 31'h0})
            `CHK(check_byte_out, pat[7:0] ^ {8{f[0]}})
            i_spi_host_model.rd(`ADDR_SPI_OUTPUT_ERROR_INJECT, d);
            `CHK(d, {31'h0, m[5]})
        end
        // clock enable low: a write to the inject bit must be lost
        ce = 1'b0;
        i_spi_host_model.strobe(1'b1, `ADDR_SPI_OUTPUT_ERROR_INJECT, 32'h1);
        ce = 1'b1;
        i_spi_host_model.rd(`ADDR_SPI_OUTPUT_ERROR_INJECT, d);
        `CHK(d, 32'h0)
        spi_slave_in_reset = 1'b1;
        i_spi_host_model.rd(`ADDR_MAC_RESET_CLOCK_STATUS, d);
        `CHK(d, 32'h0)
        spi_slave_in_reset = 1'b0;
        key_run(16'h4f1c, 16'h4f1c, 16'hc1f4, 1);
        key_run(16'h4f1c, 16'h1234, 16'hc1f4, 0);
        software_power_down_bit = 1'b1;
        key_run(16'h4f1c, 16'h4f1c, 16'hc1f4, 0);
        software_power_down_bit = 1'b0;
        short_run(2, 0);
        short_run(3, 1);
        key_run(16'h6f1a, 16'h6f1a, 16'ha1f6, 0);
        wait_core(1'b0);
        `CHK(core_on_oscillator, 1'b1)
        i_spi_host_model.rd(`ADDR_MAC_RESET_CLOCK_STATUS, d);
        `CHK(d, 32'h1)
        xtal_on = 1'b1;
        rst = 1'b1;
        @(posedge clk_sys);
        #1 rst = 1'b0;
        wait_core(1'b0);
        i_spi_host_model.rd(`ADDR_MAC_RESET_CLOCK_STATUS, d);
        `CHK(d, 32'h3)
        // oscillator lost: bit 0 follows it, crystal release stays
        oscillator_clock_ready = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        i_spi_host_model.rd(`ADDR_MAC_RESET_CLOCK_STATUS, d);
        `CHK(d, 32'h2)
        end_of_test();
    end
endmodule // mac_reset_ctrl_test
`default_nettype wire
